// *** pkg/flash_cmd_map.svh ***
// Addresses, command codes, register offsets and timing of the command path
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
`define FCI_A_UNLK_A 14'h1554
`define FCI_A_UNLK_B 14'h2aa8
`define FCI_A_PROT_A 14'h2a54
`define FCI_A_PROT_B 14'h15a8
`define FCI_D_UNLK_A 8'ha8
`define FCI_D_UNLK_B 8'h54
`define FCI_D_RESET 8'hf0
`define FCI_D_PROG 8'ha0
`define FCI_D_ERASE 8'h80
`define FCI_D_BLK 8'h30
`define FCI_D_CHIP 8'h10
`define FCI_D_SUSP 8'hb0
`define FCI_D_SETP 8'hc0
`define FCI_D_RDP 8'h90
`define FCI_D_BTU 8'hc1
`define FCI_D_CTU 16'hffff
`define FCI_D_CTP 16'hfffb
`define FCI_ODD_WORD 2'h2
`define FCI_DUMMY 16'h0000
`define FCI_PR_RST 16'hffff
`define FCI_PR_CODE 15
`define FCI_NBLK 11
`define FCI_BLK_LSB 13
`define FCI_SB_POLL 7
`define FCI_SB_TGL_A 6
`define FCI_SB_ERR 5
`define FCI_SB_TMO 3
`define FCI_SB_TGL_B 2
`define FCI_CFG_MEN 0
`define FCI_CFG_REMAP 1
`define FCI_CFG_SGT 2
`define FCI_CFG_RST 3'h6
`define FCI_REG_CFG 4'h0
`define FCI_REG_STAT 4'h4
`define FCI_REG_PROT 4'h8
`define FCI_BE_TMO_US 96
`define FCI_CLK_MHZ 200
`endif

// *** pkg/flash_cmd_pkg.sv ***
// Types of the flash command interface
package flash_cmd_pkg;
  typedef enum logic [3:0] {
    ST_READ, ST_UNL1, ST_UNL2, ST_E80, ST_UNL3, ST_UNL4, ST_PROG,
    ST_BE_WAIT, ST_BUSY_P, ST_BUSY_E, ST_PUNL1, ST_PUNL2, ST_SETP,
    ST_RDPROT, ST_BTU
  } fci_state_e;
  typedef struct packed {
    fci_state_e st;
    logic susp;
    logic err;
    logic perr;
    logic cunp;
    logic bunp;
    logic tgl;
    logic strap;
    logic chip;
    logic prog_go;
    logic erase_go;
    logic susp_p;
    logic res_p;
    logic abort_p;
    logic rvalid;
    logic cprot;
    logic [10:0] bprot;
    logic [2:0] cfg;
    logic [3:0] nblk;
    logic [15:0] tmr;
    logic [15:0] pr;
    logic [15:0] rdata;
    logic [15:0] reg_rdata;
    logic [18:0] op_addr;
    logic [15:0] op_data;
  } fci_s;
endpackage : flash_cmd_pkg

// *** verilog/erase_blk_mem.sv ***
// Small memory of block numbers queued for a block erase
`timescale 1ns/1ps
module erase_blk_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int W = 6
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  // Registered read port
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data valid the cycle after the index is presented
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : erase_blk_mem

// *** verilog/flash_command_interface.sv ***
// Coded command decoder and memory configuration of the on-chip flash
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module flash_command_interface #(
  parameter int BE_TMO_CYC = `FCI_BE_TMO_US * `FCI_CLK_MHZ,
  parameter int BLK_DEPTH = 8,
  parameter int BLK_AW = 3
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // CPU flash access
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [18:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_fetch_in_flash,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  // Array data for the current read address
  input wire logic [15:0] i_array_rdata,
  // Embedded operation controller
  output logic o_prog_go,
  output logic o_erase_go,
  output logic o_chip_erase,
  output logic o_suspend,
  output logic o_resume,
  output logic o_abort,
  output logic [18:0] o_op_addr,
  output logic [15:0] o_op_data,
  output logic [3:0] o_blk_count,
  input wire logic [BLK_AW-1:0] i_blk_idx,
  output logic [5:0] o_blk_num,
  input wire logic i_op_done,
  input wire logic i_op_error,
  // Protection and memory map
  output logic o_code_protect,
  output logic [10:0] o_block_protect,
  input wire logic i_ext_access_pin,
  output logic o_internal_mem_enable,
  output logic o_low_segment_remap,
  output logic o_segmentation_disable,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata
);
  flash_cmd_pkg::fci_s s_reg, s_next;
  logic blk_we;
  logic [BLK_AW-1:0] blk_waddr;
  logic wr;
  logic rd;

  // Only low offset bits take part in command matching
  function automatic logic at(input logic [18:0] a, input logic [13:0] c);
    return a[13:0] == c;
  endfunction : at

  function automatic logic odd_word(input logic [18:0] a);
    return a[1:0] == `FCI_ODD_WORD;
  endfunction : odd_word

  function automatic logic busy(input flash_cmd_pkg::fci_state_e st);
    return st == flash_cmd_pkg::ST_BUSY_P || st == flash_cmd_pkg::ST_BUSY_E
      || st == flash_cmd_pkg::ST_BE_WAIT;
  endfunction : busy

  assign wr = i_wr_stb && s_reg.cfg[`FCI_CFG_MEN];
  assign rd = i_rd_stb && s_reg.cfg[`FCI_CFG_MEN];

  always_comb begin
    flash_cmd_pkg::fci_state_e base;
    logic [7:0] d;
    s_next = s_reg;
    blk_we = 1'b0;
    blk_waddr = s_reg.nblk[BLK_AW-1:0];
    d = i_wdata[7:0];
    base = s_reg.st;
    s_next.prog_go = 1'b0;
    s_next.erase_go = 1'b0;
    s_next.susp_p = 1'b0;
    s_next.res_p = 1'b0;
    s_next.abort_p = 1'b0;
    s_next.rvalid = 1'b0;
    s_next.rdata = `FCI_DUMMY;
    s_next.reg_rdata = `FCI_DUMMY;
    // Strap is caught on the first clock after reset release
    if (!s_reg.strap) begin
      s_next.strap = 1'b1;
      s_next.cfg[`FCI_CFG_MEN] = i_ext_access_pin;
    end
    if (i_reg_wr && i_reg_addr == `FCI_REG_CFG) begin
      s_next.cfg = i_reg_wdata[2:0];
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `FCI_REG_CFG: s_next.reg_rdata = {13'h0000, s_reg.cfg};
        `FCI_REG_STAT: s_next.reg_rdata = {5'h00, s_reg.nblk, s_reg.perr,
          s_reg.err, s_reg.susp, s_reg.st};
        `FCI_REG_PROT: s_next.reg_rdata = s_reg.pr;
        default: s_next.reg_rdata = `FCI_DUMMY;
      endcase
    end
    // Flash reads: status while busy, dummy inside a sequence
    if (rd) begin
      s_next.rvalid = 1'b1;
      if (busy(s_reg.st) || s_reg.err) begin
        s_next.tgl = ~s_reg.tgl;
        s_next.rdata[`FCI_SB_POLL] = (s_reg.st == flash_cmd_pkg::ST_BUSY_P)
          ? ~s_reg.op_data[`FCI_SB_POLL] : 1'b0;
        s_next.rdata[`FCI_SB_TGL_A] = s_reg.tgl;
        s_next.rdata[`FCI_SB_TGL_B] = s_reg.tgl;
        s_next.rdata[`FCI_SB_ERR] = s_reg.err;
        s_next.rdata[`FCI_SB_TMO] = s_reg.st != flash_cmd_pkg::ST_BE_WAIT;
      end else if (s_reg.st == flash_cmd_pkg::ST_RDPROT) begin
        if (odd_word(i_addr)) begin
          s_next.rdata = s_reg.pr;
        end
      end else if (s_reg.st == flash_cmd_pkg::ST_READ) begin
        s_next.rdata = i_array_rdata;
      end
    end
    // Erase starts when the confirm window runs out
    if (s_reg.st == flash_cmd_pkg::ST_BE_WAIT) begin
      if (s_reg.tmr == 16'h0000) begin
        s_next.erase_go = 1'b1;
        s_next.st = flash_cmd_pkg::ST_BUSY_E;
      end else begin
        s_next.tmr = s_reg.tmr - 16'h0001;
      end
    end
    // Protection read mode ends with any write other than a code protect word fetched from flash, which is decoded anew
    if (s_reg.st == flash_cmd_pkg::ST_RDPROT) begin
      base = flash_cmd_pkg::ST_READ;
    end else if (s_reg.st == flash_cmd_pkg::ST_BE_WAIT
        && s_reg.tmr == 16'h0000) begin
      // A write in the cycle the window closes meets a running erase
      base = flash_cmd_pkg::ST_BUSY_E;
    end
    if (wr) begin
      if (i_wdata == `FCI_D_CTU && i_fetch_in_flash) begin
        s_next.cunp = 1'b1;
      end else if (i_wdata == `FCI_D_CTP && i_fetch_in_flash) begin
        s_next.cunp = 1'b0;
      end else begin
        // Any cycle that does not fit falls back to read mode, except in ST_BUSY_P and ST_BUSY_E, which stay busy
        s_next.st = flash_cmd_pkg::ST_READ;
        case (base)
          flash_cmd_pkg::ST_READ: begin
            if (d == `FCI_D_RESET) begin
              s_next.err = 1'b0;
            end else if (d == `FCI_D_UNLK_A && at(i_addr, `FCI_A_UNLK_A)) begin
              s_next.st = flash_cmd_pkg::ST_UNL1;
            end else if (d == `FCI_D_UNLK_A && at(i_addr, `FCI_A_PROT_A)) begin
              s_next.st = flash_cmd_pkg::ST_PUNL1;
            end else if (d == `FCI_D_BLK && s_reg.susp) begin
              s_next.susp = 1'b0;
              s_next.res_p = 1'b1;
              s_next.st = flash_cmd_pkg::ST_BUSY_E;
            end
          end
          flash_cmd_pkg::ST_UNL1: begin
            if (d == `FCI_D_UNLK_B && at(i_addr, `FCI_A_UNLK_B)) begin
              s_next.st = flash_cmd_pkg::ST_UNL2;
            end
          end
          flash_cmd_pkg::ST_UNL2: begin
            if (d == `FCI_D_PROG && at(i_addr, `FCI_A_UNLK_A)) begin
              s_next.st = flash_cmd_pkg::ST_PROG;
            end else if (d == `FCI_D_ERASE && at(i_addr, `FCI_A_UNLK_A)
                && !s_reg.susp) begin
              s_next.st = flash_cmd_pkg::ST_E80;
            end
            // F0h here simply lands in read mode
          end
          flash_cmd_pkg::ST_E80: begin
            if (d == `FCI_D_UNLK_A && at(i_addr, `FCI_A_UNLK_A)) begin
              s_next.st = flash_cmd_pkg::ST_UNL3;
            end
          end
          flash_cmd_pkg::ST_UNL3: begin
            if (d == `FCI_D_UNLK_B && at(i_addr, `FCI_A_UNLK_B)) begin
              s_next.st = flash_cmd_pkg::ST_UNL4;
            end
          end
          flash_cmd_pkg::ST_UNL4: begin
            if (d == `FCI_D_BLK) begin
              blk_we = 1'b1;
              blk_waddr = '0;
              s_next.nblk = 4'h1;
              s_next.tmr = BE_TMO_CYC[15:0];
              s_next.st = flash_cmd_pkg::ST_BE_WAIT;
            end else if (d == `FCI_D_CHIP && at(i_addr, `FCI_A_UNLK_A)) begin
              s_next.chip = 1'b1;
              s_next.erase_go = 1'b1;
              s_next.st = flash_cmd_pkg::ST_BUSY_E;
            end
          end
          flash_cmd_pkg::ST_PROG: begin
            s_next.op_addr = i_addr;
            s_next.op_data = i_wdata;
            s_next.prog_go = 1'b1;
            s_next.st = flash_cmd_pkg::ST_BUSY_P;
          end
          flash_cmd_pkg::ST_BE_WAIT: begin
            if (d == `FCI_D_BLK) begin
              // Blocks beyond the queue depth are dropped silently
              blk_we = s_reg.nblk < 4'(BLK_DEPTH);
              if (blk_we) begin
                s_next.nblk = s_reg.nblk + 4'h1;
              end
              s_next.tmr = BE_TMO_CYC[15:0];
              s_next.st = flash_cmd_pkg::ST_BE_WAIT;
            end else if (d == `FCI_D_SUSP) begin
              // Suspend cuts the window short: start, then hold at once
              s_next.erase_go = 1'b1;
              s_next.susp_p = 1'b1;
              s_next.susp = 1'b1;
            end else begin
              s_next.abort_p = 1'b1;
              s_next.nblk = 4'h0;
            end
          end
          flash_cmd_pkg::ST_BUSY_P, flash_cmd_pkg::ST_BUSY_E: begin
            s_next.st = base;
            if (d == `FCI_D_RESET) begin
              s_next.abort_p = 1'b1;
              s_next.err = 1'b0;
              s_next.chip = 1'b0;
              s_next.st = flash_cmd_pkg::ST_READ;
            end else if (d == `FCI_D_SUSP
                && base == flash_cmd_pkg::ST_BUSY_E) begin
              s_next.susp_p = 1'b1;
              s_next.susp = 1'b1;
              s_next.st = flash_cmd_pkg::ST_READ;
            end
          end
          flash_cmd_pkg::ST_PUNL1: begin
            if (d == `FCI_D_UNLK_B && at(i_addr, `FCI_A_PROT_B)) begin
              s_next.st = flash_cmd_pkg::ST_PUNL2;
            end
          end
          flash_cmd_pkg::ST_PUNL2: begin
            if (at(i_addr, `FCI_A_PROT_A)) begin
              if (d == `FCI_D_SETP) begin
                s_next.st = flash_cmd_pkg::ST_SETP;
              end else if (d == `FCI_D_RDP) begin
                s_next.st = flash_cmd_pkg::ST_RDPROT;
              end else if (d == `FCI_D_BTU) begin
                s_next.st = flash_cmd_pkg::ST_BTU;
              end
            end
          end
          flash_cmd_pkg::ST_SETP: begin
            if (odd_word(i_addr)) begin
              if (|(~s_reg.pr & i_wdata)) begin
                s_next.perr = 1'b1;
              end else begin
                s_next.pr = i_wdata;
              end
            end
          end
          flash_cmd_pkg::ST_BTU: begin
            if (d == `FCI_D_RESET) begin
              s_next.bunp = 1'b1;
            end
          end
          default: s_next.st = flash_cmd_pkg::ST_READ;
        endcase
      end
    end
    // Done is taken after decoding: a write cannot undo it, and an error
    // that meets a read/reset in one cycle stays set
    if (i_op_done && (s_reg.st == flash_cmd_pkg::ST_BUSY_P
        || s_reg.st == flash_cmd_pkg::ST_BUSY_E)) begin
      if (i_op_error) begin
        s_next.err = 1'b1;
      end else begin
        s_next.st = flash_cmd_pkg::ST_READ;
        s_next.chip = 1'b0;
      end
    end
    s_next.cprot = ~s_next.pr[`FCI_PR_CODE] & ~s_next.cunp;
    s_next.bprot = ~s_next.pr[`FCI_NBLK-1:0] & ~{`FCI_NBLK{s_next.bunp}};
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '{st: flash_cmd_pkg::ST_READ, cfg: `FCI_CFG_RST,
        pr: `FCI_PR_RST, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  erase_blk_mem #(.DEPTH(BLK_DEPTH), .AW(BLK_AW), .W(6)) u_blk_mem (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(blk_we),
    .i_waddr(blk_waddr),
    .i_wdata(i_addr[18:`FCI_BLK_LSB]),
    .i_raddr(i_blk_idx),
    .o_rdata(o_blk_num)
  );

  assign o_rdata = s_reg.rdata;
  assign o_rvalid = s_reg.rvalid;
  assign o_prog_go = s_reg.prog_go;
  assign o_erase_go = s_reg.erase_go;
  assign o_chip_erase = s_reg.chip;
  assign o_suspend = s_reg.susp_p;
  assign o_resume = s_reg.res_p;
  assign o_abort = s_reg.abort_p;
  assign o_op_addr = s_reg.op_addr;
  assign o_op_data = s_reg.op_data;
  assign o_blk_count = s_reg.nblk;
  assign o_code_protect = s_reg.cprot;
  assign o_block_protect = s_reg.bprot;
  assign o_internal_mem_enable = s_reg.cfg[`FCI_CFG_MEN];
  assign o_low_segment_remap = s_reg.cfg[`FCI_CFG_REMAP];
  assign o_segmentation_disable = s_reg.cfg[`FCI_CFG_SGT];
  assign o_reg_rdata = s_reg.reg_rdata;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  busy_status_a: assert property (
    rd && s_reg.st == flash_cmd_pkg::ST_BUSY_E |=> o_rvalid
      && !o_rdata[`FCI_SB_POLL] && o_rdata[`FCI_SB_TMO])
    else $error("erase read did not give status");
  toggle_a: assert property (
    rd && s_reg.st == flash_cmd_pkg::ST_BUSY_E ##1
      rd && s_reg.st == flash_cmd_pkg::ST_BUSY_E
      |=> o_rdata[`FCI_SB_TGL_A] != $past(o_rdata[`FCI_SB_TGL_A]))
    else $error("toggle bit stood still");
  prog_start_a: assert property (
    wr && s_reg.st == flash_cmd_pkg::ST_PROG && !i_fetch_in_flash
      |=> o_prog_go && o_op_data == $past(i_wdata)
      ##1 !o_prog_go && s_reg.st == flash_cmd_pkg::ST_BUSY_P)
    else $error("program did not start");
  be_window_a: assert property (
    s_reg.st == flash_cmd_pkg::ST_BE_WAIT && s_reg.tmr == 16'h0000 && !wr
      |=> o_erase_go && s_reg.st == flash_cmd_pkg::ST_BUSY_E)
    else $error("erase did not start at window end");
  chip_erase_a: assert property (
    wr && s_reg.st == flash_cmd_pkg::ST_UNL4 && i_wdata[7:0] == `FCI_D_CHIP
      && at(i_addr, `FCI_A_UNLK_A) |=> o_erase_go && o_chip_erase)
    else $error("chip erase not started");
  suspend_a: assert property (
    wr && s_reg.st == flash_cmd_pkg::ST_BUSY_E
      && i_wdata[7:0] == `FCI_D_SUSP && !i_fetch_in_flash
      |=> o_suspend && s_reg.susp && s_reg.st == flash_cmd_pkg::ST_READ)
    else $error("erase not suspended");
  resume_a: assert property (
    wr && s_reg.st == flash_cmd_pkg::ST_READ && s_reg.susp
      && i_wdata[7:0] == `FCI_D_BLK && !i_fetch_in_flash
      |=> o_resume && s_reg.st == flash_cmd_pkg::ST_BUSY_E)
    else $error("erase not resumed");
  prot_error_a: assert property (
    wr && s_reg.st == flash_cmd_pkg::ST_SETP && odd_word(i_addr)
      && |(~s_reg.pr & i_wdata) && !i_fetch_in_flash
      |=> s_reg.perr && s_reg.pr == $past(s_reg.pr))
    else $error("protection bit set back to one");
  code_unprot_a: assert property (
    wr && i_wdata == `FCI_D_CTU && !i_fetch_in_flash
      |=> s_reg.cunp == $past(s_reg.cunp))
    else $error("foreign write lifted code protection");
  strap_a: assert property (
    !s_reg.strap |=> o_internal_mem_enable == $past(i_ext_access_pin))
    else $error("access pin not latched");
  abort_seq_a: assert property (
    wr && s_reg.st == flash_cmd_pkg::ST_UNL1 && !i_fetch_in_flash
      && i_wdata[7:0] != `FCI_D_UNLK_B |=> s_reg.st == flash_cmd_pkg::ST_READ)
    else $error("bad unlock not aborted");

  prog_c: cover property (wr && s_reg.st == flash_cmd_pkg::ST_PROG);
  multi_blk_c: cover property (s_reg.nblk == 4'h2 ##1 o_erase_go);
  susp_c: cover property (o_suspend ##[1:50] o_resume);
  rdprot_c: cover property (rd && s_reg.st == flash_cmd_pkg::ST_RDPROT);
endmodule : flash_command_interface

// *** bench/op_ctrl_model.sv ***
// Behavioural model of the embedded program and erase controller
`timescale 1ns/1ps
module op_ctrl_model #(
  parameter int DLY = 40
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Requests from the command decoder
  input wire logic i_go,
  input wire logic i_suspend,
  input wire logic i_resume,
  input wire logic i_abort,
  // Completion
  output logic o_done,
  output logic o_error
);
  int cnt_reg;
  logic run_reg;
  logic hold_reg;
  // Failures are never injected, so the error line stays low
  assign o_error = 1'b0;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 0;
      run_reg <= 1'b0;
      hold_reg <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_go) begin
        // Suspend or abort may come with the start pulse itself
        run_reg <= !i_abort;
        hold_reg <= i_suspend;
        cnt_reg <= DLY;
      end else if (i_abort) begin
        run_reg <= 1'b0;
      end else if (i_suspend) begin
        hold_reg <= 1'b1;
      end else if (i_resume) begin
        hold_reg <= 1'b0;
      end else if (run_reg && !hold_reg) begin
        if (cnt_reg == 0) begin
          o_done <= 1'b1;
          run_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg - 1;
        end
      end
    end
  end
endmodule : op_ctrl_model

// *** bench/tb_top.sv ***
// Self-checking bench of the flash command interface
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module tb_top;
  localparam int TMO = 20;
  typedef struct {logic [15:0] e; logic [15:0] m; bit t;} note_s;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr_stb = 1'b0, i_rd_stb = 1'b0, i_fetch_in_flash = 1'b0;
  logic [18:0] i_addr = '0;
  logic [15:0] i_wdata = '0, i_array_rdata = '0, i_reg_wdata = '0;
  logic [2:0] i_blk_idx = '0;
  logic [3:0] i_reg_addr = '0;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_op_done, i_op_error;
  logic i_ext_access_pin = 1'b0;
  logic [15:0] o_rdata, o_op_data, o_reg_rdata;
  logic o_rvalid, o_prog_go, o_erase_go, o_chip_erase, o_suspend;
  logic o_resume, o_abort, o_code_protect, o_internal_mem_enable;
  logic o_low_segment_remap, o_segmentation_disable;
  logic [18:0] o_op_addr;
  logic [3:0] o_blk_count;
  logic [5:0] o_blk_num;
  logic [10:0] o_block_protect;
  logic [4:0] pl;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc_cnt = 0;
  logic [31:0] seed = 32'hffb25a95;
  logic [15:0] pd, last_st = '0;
  logic rr_q = 1'b0;
  note_s q[$];
  note_s n;
  assign pl = {o_abort, o_resume, o_suspend, o_erase_go, o_prog_go};

  flash_command_interface #(.BE_TMO_CYC(TMO)) flash_command_interface_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wr_stb(i_wr_stb),
    .i_rd_stb(i_rd_stb), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_fetch_in_flash(i_fetch_in_flash), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_array_rdata(i_array_rdata),
    .o_prog_go(o_prog_go), .o_erase_go(o_erase_go),
    .o_chip_erase(o_chip_erase), .o_suspend(o_suspend),
    .o_resume(o_resume), .o_abort(o_abort), .o_op_addr(o_op_addr),
    .o_op_data(o_op_data), .o_blk_count(o_blk_count),
    .i_blk_idx(i_blk_idx), .o_blk_num(o_blk_num), .i_op_done(i_op_done),
    .i_op_error(i_op_error), .o_code_protect(o_code_protect),
    .o_block_protect(o_block_protect), .i_ext_access_pin(i_ext_access_pin),
    .o_internal_mem_enable(o_internal_mem_enable),
    .o_low_segment_remap(o_low_segment_remap),
    .o_segmentation_disable(o_segmentation_disable),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

  op_ctrl_model #(.DLY(40)) op_ctrl_model_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_go(o_prog_go | o_erase_go),
    .i_suspend(o_suspend), .i_resume(o_resume), .i_abort(o_abort),
    .o_done(i_op_done), .o_error(i_op_error));

  initial begin
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [15:0] e, v);
    n_compared++;
    if (e !== v) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, v);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk_sys);
  endtask : cyc

  task automatic wr(input logic [18:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_clk_sys);
    i_wr_stb <= 1'b0;
  endtask : wr

  // Array data is random, so a stale or dummy answer cannot match
  task automatic rd(input logic [18:0] a, input logic [15:0] e, m,
                    input bit t, arr);
    seed = xs(seed);
    q.push_back('{arr ? seed[15:0] : e, m, t});
    @(posedge i_clk_sys);
    i_addr <= a;
    i_array_rdata <= seed[15:0];
    i_rd_stb <= 1'b1;
    @(posedge i_clk_sys);
    i_rd_stb <= 1'b0;
  endtask : rd

  // Two status reads with no gap, each checked against the one before
  task automatic rd2(input logic [18:0] a, input logic [15:0] m);
    q.push_back('{16'h0000, m, 1'b1});
    q.push_back('{16'h0000, m, 1'b1});
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rd_stb <= 1'b0;
  endtask : rd2

  task automatic rw(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask : rw

  task automatic rg(input logic [3:0] a, input logic [15:0] e, m);
    q.push_back('{e, m, 1'b0});
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
  endtask : rg

  // Counts edges until pulse k is seen; it must land inside lo..hi
  task automatic wp(input int k, lo, hi);
    int c;
    c = 0;
    do begin
      @(posedge i_clk_sys);
      c++;
    end while (pl[k] !== 1'b1 && c <= hi);
    chk("pulse delay", 16'h1, {15'h0, c >= lo && c <= hi});
  endtask : wp

  task automatic unl(input logic [7:0] c);
    wr(19'h01554, 16'h00a8);
    wr(19'h02aa8, 16'h0054);
    wr(19'h01554, {8'h00, c});
  endtask : unl

  task automatic pu(input logic [7:0] c);
    wr(19'h02a54, 16'h00a8);
    wr(19'h015a8, 16'h0054);
    wr(19'h02a54, {8'h00, c});
  endtask : pu

  always @(posedge i_clk_sys) begin
    if (o_rvalid === 1'b1 || rr_q) begin
      if (q.size() == 0) begin
        chk("unexpected read", 16'h0, 16'h1);
      end else begin
        n = q.pop_front();
        if (n.t) n.e = ~last_st;
        chk("read data", n.e & n.m, (rr_q ? o_reg_rdata : o_rdata) & n.m);
        last_st = rr_q ? o_reg_rdata : o_rdata;
      end
    end
    rr_q <= i_reg_rd;
    cyc_cnt++;
    if (cyc_cnt == 8000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    cyc(10);
    i_rst <= 1'b0;
    cyc(2);
    chk("mem enable", 16'h0, {15'h0, o_internal_mem_enable});
    rg(`FCI_REG_CFG, 16'h0006, 16'hffff);
    rg(4'hc, 16'h0000, 16'hffff);
    rw(`FCI_REG_CFG, 16'h0001);
    cyc(2);
    chk("mem enable", 16'h1, {15'h0, o_internal_mem_enable});
    chk("remap", 16'h0, {15'h0, o_low_segment_remap});
    chk("seg disable", 16'h0, {15'h0, o_segmentation_disable});
    $display("test config done");
    rd(19'h00100, 0, 16'hffff, 0, 1);
    wr(19'h01554, 16'h00a8);
    rd(19'h00100, 16'h0000, 16'hffff, 0, 0);
    wr(19'h02aa8, 16'h0054);
    wr(19'h05000, 16'h00f0);
    rd(19'h00102, 0, 16'hffff, 0, 1);
    wr(19'h01554, 16'h00a8);
    wr(19'h02aa8, 16'h0055);
    rd(19'h00104, 0, 16'hffff, 0, 1);
    $display("test read reset done");
    wr(19'h7d554, 16'h00a8);
    wr(19'h6aaa8, 16'h0054);
    wr(19'h45554, 16'h00a0);
    seed = xs(seed);
    pd = seed[15:0];
    wr(19'h12346, pd);
    wp(0, 1, 2);
    chk("op addr", 16'h2346, o_op_addr[15:0]);
    chk("op data", pd, o_op_data);
    rd(19'h12346, {8'h00, ~pd[7], 7'h00}, 16'h0080, 0, 0);
    cyc(50);
    rd(19'h12346, 0, 16'hffff, 0, 1);
    $display("test program done");
    unl(8'h80);
    wr(19'h01554, 16'h00a8);
    wr(19'h02aa8, 16'h0054);
    wr(19'h04000, 16'h0030);
    rd(19'h00000, 16'h0000, 16'h0008, 0, 0);
    wr(19'h0a000, 16'h0030);
    wp(1, TMO, TMO + 4);
    chk("blk count", 16'h2, {12'h0, o_blk_count});
    chk("blk num", 16'h2, {10'h0, o_blk_num});
    i_blk_idx <= 3'h1;
    cyc(2);
    chk("blk num", 16'h5, {10'h0, o_blk_num});
    rd(19'h00000, 16'h0008, 16'h0088, 0, 0);
    rd2(19'h00000, 16'h0044);
    wr(19'h03000, 16'h00b0);
    wp(2, 1, 2);
    wr(19'h07000, 16'h0030);
    wp(3, 1, 2);
    cyc(60);
    rd(19'h00000, 0, 16'hffff, 0, 1);
    $display("test block erase done");
    unl(8'h80);
    unl(8'h30);
    wr(19'h00000, 16'h0055);
    wp(4, 1, 2);
    chk("blk count", 16'h0, {12'h0, o_blk_count});
    $display("test erase abort done");
    unl(8'h80);
    unl(8'h10);
    wp(1, 1, 3);
    chk("chip erase", 16'h1, {15'h0, o_chip_erase});
    cyc(60);
    $display("test chip erase done");
    pu(8'h90);
    rd(19'h00006, 16'hffff, 16'hffff, 0, 0);
    wr(19'h00000, 16'h00f0);
    pu(8'hc0);
    wr(19'h00002, 16'h7ffe);
    cyc(2);
    chk("code prot", 16'h1, {15'h0, o_code_protect});
    chk("blk prot", 16'h1, {5'h0, o_block_protect});
    pu(8'hc0);
    wr(19'h00004, 16'h7ffc);
    rg(`FCI_REG_PROT, 16'h7ffe, 16'hffff);
    pu(8'hc0);
    wr(19'h00002, 16'hffff);
    rg(`FCI_REG_PROT, 16'h7ffe, 16'hffff);
    rg(`FCI_REG_STAT, 16'h0040, 16'h0040);
    wr(19'h00000, 16'hffff);
    cyc(2);
    chk("code prot", 16'h1, {15'h0, o_code_protect});
    i_fetch_in_flash <= 1'b1;
    wr(19'h00000, 16'hffff);
    cyc(2);
    chk("code prot", 16'h0, {15'h0, o_code_protect});
    wr(19'h00000, 16'hfffb);
    cyc(2);
    chk("code prot", 16'h1, {15'h0, o_code_protect});
    i_fetch_in_flash <= 1'b0;
    pu(8'hc1);
    wr(19'h00000, 16'h00f0);
    cyc(2);
    chk("blk prot", 16'h0, {5'h0, o_block_protect});
    $display("test protection done");
    cyc(3);
    i_ext_access_pin <= 1'b1;
    i_rst <= 1'b1;
    cyc(10);
    i_rst <= 1'b0;
    cyc(2);
    chk("mem enable", 16'h1, {15'h0, o_internal_mem_enable});
    rg(`FCI_REG_CFG, 16'h0007, 16'hffff);
    $display("test second reset done");
    cyc(3);
    complete_run();
  end
endmodule : tb_top
